// file: hw/vps_map.svh
`ifndef VPS_MAP_SVH
`define VPS_MAP_SVH
// pixel depth encodings on depth_sel
`define VPS_DEPTH_4     2'h0
`define VPS_DEPTH_8     2'h1
`define VPS_DEPTH_24    2'h2
// video timing defaults (pixels / lines)
`define VPS_H_ACTIVE    640
`define VPS_H_TOTAL     800
`define VPS_HS_START    656
`define VPS_HS_END      752
`define VPS_V_ACTIVE    480
`define VPS_V_TOTAL     525
`define VPS_VS_START    490
`define VPS_VS_END      492
// reset values
`define VPS_RST_PIXEL   8'h00
`endif

// file: hw/vps_pkg.sv
`default_nettype none
package vps_pkg;
    typedef enum logic [1:0] {
        VPS_FETCH_IDLE,
        VPS_FETCH_WAIT
    } vps_fetch_t;
endpackage
`default_nettype wire

// file: hw/vps_word_shifter.sv
`include "vps_map.svh"
`default_nettype none
// ----------------------------------------------------------------
// word shifter: one 32-bit word into pixels, lsb first
// ----------------------------------------------------------------
module vps_word_shifter #(
    parameter int WORD_W = 32
) (
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    input  wire logic              load,
    input  wire logic [WORD_W-1:0] word_in,
    input  wire logic              step,
    input  wire logic [1:0]        depth_sel,
    output var  logic [7:0]        pixel,
    output var  logic [3:0]        slots_left
);
    logic [WORD_W-1:0] shreg;

    initial begin
        if (WORD_W != 32) $error("word width must be 32");
    end

    // low bits leave first; nibble pixels take bits 0-3 then 4-7
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            shreg      <= '0;
            slots_left <= 4'h0;
        end else if (load) begin
            shreg      <= word_in;
            case (depth_sel)
                `VPS_DEPTH_4:  slots_left <= 4'h8;
                `VPS_DEPTH_24: slots_left <= 4'h1;
                default:       slots_left <= 4'h4;
            endcase
        end else if (step) begin
            case (depth_sel)
                `VPS_DEPTH_4:  shreg <= shreg >> 4;
                `VPS_DEPTH_24: shreg <= shreg;
                default:       shreg <= shreg >> 8;
            endcase
            slots_left <= slots_left - 4'h1;
        end
    end

    // nibble mode leaves the upper half zero; the palette mask covers it
    always_comb begin
        if (depth_sel == `VPS_DEPTH_4) begin
            pixel = {4'h0, shreg[3:0]};
        end else begin
            pixel = shreg[7:0];
        end
    end
endmodule // vps_word_shifter
`default_nettype wire

// file: hw/vps_pixel_shifter.sv
// What this block does
// - accepts 32-bit vram serial words and makes an 8-bit pixel stream.
// - pixels leave every word least significant bits first.
// - nibble mode sends bits 0-3 then bits 4-7 of each byte.
// - memory is a linear array of equal pixels from bit 0 of byte 0.
// - 4-bit and 8-bit pixel modes feed an 8-bit palette dac directly.
// - in compatibility mode the block owns the random port as plain dram.
// - in acceleration mode it leaves the random port, still shifts, syncs.
// - memory is one 32-bit bank or two 16-bit banks.
// - two-bank maps may be word-interleaved or not.
// - in 24-bit mode exactly one pixel goes out per shift clock.
// - the address mapping is the same for interlaced and progressive scan.
// - each transfer cycle is requested by an active-low request output.
`include "vps_map.svh"
`default_nettype none
module vps_pixel_shifter
    import vps_pkg::*;
#(
    parameter int H_ACTIVE = `VPS_H_ACTIVE,
    parameter int H_TOTAL  = `VPS_H_TOTAL,
    parameter int HS_START = `VPS_HS_START,
    parameter int HS_END   = `VPS_HS_END,
    parameter int V_ACTIVE = `VPS_V_ACTIVE,
    parameter int V_TOTAL  = `VPS_V_TOTAL,
    parameter int VS_START = `VPS_VS_START,
    parameter int VS_END   = `VPS_VS_END
) (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        accel_mode,
    input  wire logic [1:0]  depth_sel,
    input  wire logic        split_banks,
    input  wire logic        bank_swap,
    input  wire logic        interlaced,
    input  wire logic [31:0] serial_data,
    input  wire logic        serial_valid,
    output var  logic        transfer_request_n,
    output var  logic        shift_clock,
    output var  logic        random_port_own,
    output var  logic [7:0]  pixel_out,
    output var  logic        blank_n,
    output var  logic        hsync,
    output var  logic        vsync
);
    // ------------------------------------------------------------
    // parameter checks
    // ------------------------------------------------------------
    initial begin
        if (HS_END >= H_TOTAL || H_ACTIVE >= HS_START) begin
            $error("bad horizontal timing");
        end
        if (VS_END >= V_TOTAL || V_ACTIVE >= VS_START) begin
            $error("bad vertical timing");
        end
    end

    // ------------------------------------------------------------
    // raster counters
    // ------------------------------------------------------------
    logic [11:0] hcount;
    logic [11:0] vcount;
    logic        field;
    logic        active;
    logic        line_end;

    assign line_end = (hcount == 12'(H_TOTAL - 1));
    assign active   = (hcount < 12'(H_ACTIVE)) && (vcount < 12'(V_ACTIVE));

    // interlace only toggles the field at frame end, never the lines scanned or the mapping
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            hcount <= 12'h000;
            vcount <= 12'h000;
            field  <= 1'b0;
        end else if (line_end) begin
            hcount <= 12'h000;
            if (vcount == 12'(V_TOTAL - 1)) begin
                vcount <= 12'h000;
                field  <= interlaced ? ~field : 1'b0;
            end else begin
                vcount <= vcount + 12'h001;
            end
        end else begin
            hcount <= hcount + 12'h001;
        end
    end

    // sync runs in both modes
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            hsync <= 1'b0;
            vsync <= 1'b0;
        end else begin
            hsync <= (hcount >= 12'(HS_START)) && (hcount < 12'(HS_END));
            vsync <= (vcount >= 12'(VS_START)) && (vcount < 12'(VS_END));
        end
    end

    // ------------------------------------------------------------
    // random port ownership
    // ------------------------------------------------------------
    // high means this block drives the vram random port as dram
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            random_port_own <= 1'b1;
        end else begin
            random_port_own <= ~accel_mode;
        end
    end

    // ------------------------------------------------------------
    // word fetch and bank ordering
    // ------------------------------------------------------------
    logic [31:0] word_hold;
    logic        hold_full;
    logic        load;
    logic        step;
    logic [3:0]  slots_left;
    logic [7:0]  pixel;
    logic [31:0] ordered;
    vps_fetch_t  fetch;

    // non-interleaved split banks present their halves swapped
    always_comb begin
        if (split_banks && bank_swap) begin
            ordered = {serial_data[15:0], serial_data[31:16]};
        end else begin
            ordered = serial_data;
        end
    end

    // request the next word on the edge the held one enters the shifter;
    // waiting a cycle longer stalls 8-bit mode behind a slow serial port
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fetch              <= VPS_FETCH_IDLE;
            transfer_request_n <= 1'b1;
            shift_clock        <= 1'b0;
            word_hold          <= '0;
            hold_full          <= 1'b0;
        end else begin
            shift_clock <= 1'b0;
            if (load) begin
                hold_full <= 1'b0;
            end
            case (fetch)
                VPS_FETCH_IDLE: begin
                    if ((!hold_full || load) && active) begin
                        transfer_request_n <= 1'b0;
                        shift_clock        <= 1'b1;
                        fetch              <= VPS_FETCH_WAIT;
                    end
                end
                VPS_FETCH_WAIT: begin
                    if (serial_valid) begin
                        transfer_request_n <= 1'b1;
                        word_hold          <= ordered;
                        hold_full          <= 1'b1;
                        fetch              <= VPS_FETCH_IDLE;
                    end
                end
                default: begin
                    fetch              <= VPS_FETCH_IDLE;
                    transfer_request_n <= 1'b1;
                end
            endcase
        end
    end

    // prefetched word loads as the last slot drains, no gap
    assign step = active && (slots_left != 4'h0);
    assign load = hold_full &&
                  ((slots_left == 4'h0) || (step && slots_left == 4'h1));

    vps_word_shifter #(
        .WORD_W     (32)
    ) u_shift (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .load       (load),
        .word_in    (word_hold),
        .step       (step && !load),
        .depth_sel  (depth_sel),
        .pixel      (pixel),
        .slots_left (slots_left)
    );

    // ------------------------------------------------------------
    // pixel output
    // ------------------------------------------------------------
    // blanked outside the active area; 4 and 8 bit go straight to dac
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pixel_out <= `VPS_RST_PIXEL;
            blank_n   <= 1'b0;
        end else begin
            pixel_out <= step ? pixel : `VPS_RST_PIXEL;
            blank_n   <= active;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_sync_cycle;
        @(posedge clk_sys) disable iff (!rst_n)
        (hcount == 12'(HS_START)) |=> hsync;
    endproperty
    a_sync_cycle: assert property (p_sync_cycle)
        else $error("hsync not raised at sync start");

    property p_port_release;
        @(posedge clk_sys) disable iff (!rst_n)
        accel_mode |=> !random_port_own;
    endproperty
    a_port_release: assert property (p_port_release)
        else $error("random port still owned in acceleration mode");

    property p_port_own;
        @(posedge clk_sys) disable iff (!rst_n)
        !accel_mode |=> random_port_own;
    endproperty
    a_port_own: assert property (p_port_own)
        else $error("random port not owned in compatibility mode");

    property p_req_release;
        @(posedge clk_sys) disable iff (!rst_n)
        (!transfer_request_n && serial_valid) |=> transfer_request_n;
    endproperty
    a_req_release: assert property (p_req_release)
        else $error("request held after word arrived");

    property p_req_hold;
        @(posedge clk_sys) disable iff (!rst_n)
        (!transfer_request_n && !serial_valid) |=> !transfer_request_n;
    endproperty
    a_req_hold: assert property (p_req_hold)
        else $error("request dropped before word arrived");

    property p_nibble_low;
        @(posedge clk_sys) disable iff (!rst_n)
        (load && depth_sel == `VPS_DEPTH_4 && active) ##1 step
        |=> pixel_out == {4'h0, $past(word_hold[3:0], 2)};
    endproperty
    a_nibble_low: assert property (p_nibble_low)
        else $error("nibble pixel not taken from bits 0-3");

    property p_byte_low;
        @(posedge clk_sys) disable iff (!rst_n)
        (load && depth_sel == `VPS_DEPTH_8) ##1 step
        |=> pixel_out == $past(word_hold[7:0], 2);
    endproperty
    a_byte_low: assert property (p_byte_low)
        else $error("byte pixel not taken from low byte");

    property p_true_one;
        @(posedge clk_sys) disable iff (!rst_n)
        (load && depth_sel == `VPS_DEPTH_24) |=> slots_left == 4'h1;
    endproperty
    a_true_one: assert property (p_true_one)
        else $error("24-bit mode must give one pixel per word");

    property p_no_gap;
        @(posedge clk_sys) disable iff (!rst_n)
        (hold_full && step && slots_left == 4'h1) |=> slots_left != 4'h0;
    endproperty
    a_no_gap: assert property (p_no_gap)
        else $error("shifter ran dry with a word waiting");

    property p_field_flip;
        @(posedge clk_sys) disable iff (!rst_n)
        (interlaced && line_end && vcount == 12'(V_TOTAL - 1))
        |=> field != $past(field);
    endproperty
    a_field_flip: assert property (p_field_flip)
        else $error("interlace field did not change at frame end");

    property p_field_flat;
        @(posedge clk_sys) disable iff (!rst_n)
        (!interlaced && line_end && vcount == 12'(V_TOTAL - 1)) |=> !field;
    endproperty
    a_field_flat: assert property (p_field_flat)
        else $error("progressive scan left the field set");
endmodule // vps_pixel_shifter
`default_nettype wire

// file: dv/vps_vram_port_model.sv
`default_nettype none
// ----------------------------------------------
// vram serial port model
// ----------------------------------------------
module vps_vram_port_model (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        transfer_request_n,
    input  wire logic [1:0]  delay,
    output var  logic [31:0] serial_data,
    output var  logic        serial_valid
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] sent_q[$];
    int          k;
    int          wait_n;
    // no nibble of any word is zero, so a stall shows as a zero pixel
    function automatic logic [31:0] word_of(input int n);
        logic [31:0] w;
        for (int i = 0; i < 8; i++) w[4*i+:4] = 4'((8*n+i)%15+1);
        return w;
    endfunction
    // one word per request after delay cycles; idle data toggles
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            serial_valid <= 1'h0;
            serial_data  <= 32'h0;
            k = 0;
            wait_n = 0;
            sent_q.delete();
        end else if (!serial_valid && !transfer_request_n
                     && wait_n >= delay) begin
            serial_data  <= word_of(k);
            serial_valid <= 1'h1;
            sent_q.push_back(word_of(k));
            k++;
            wait_n = 0;
        end else begin
            if (!serial_valid && !transfer_request_n) wait_n++;
            serial_valid <= 1'h0;
            serial_data  <= ~serial_data;
        end
    end
endmodule // vps_vram_port_model
`default_nettype wire

// file: dv/tb_vps_pixel_shifter.sv
`default_nettype none
module tb_vps_pixel_shifter;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int HT = 40;
    localparam int VT = 10;
    logic        clk_sys, rst_n, accel_mode, split_banks, bank_swap;
    logic        interlaced, serial_valid, transfer_request_n, shift_clock;
    logic        random_port_own, blank_n, hsync, vsync;
    logic [1:0]  depth_sel, delay;
    logic [31:0] serial_data;
    logic [7:0]  pixel_out;
    logic [7:0]  pix_q[$];
    int          n_mismatch, check_count, cycles, hs_n, hs_hi, vs_hi;
    int          sh_n;
    // ----------------------------------------------
    // design and partner
    // ----------------------------------------------
    vps_pixel_shifter #(.H_ACTIVE(16), .H_TOTAL(HT), .HS_START(20),
        .HS_END(24), .V_ACTIVE(4), .V_TOTAL(VT), .VS_START(6),
        .VS_END(7)) DUT (.clk_sys(clk_sys), .rst_n(rst_n),
        .accel_mode(accel_mode), .depth_sel(depth_sel),
        .split_banks(split_banks), .bank_swap(bank_swap),
        .interlaced(interlaced), .serial_data(serial_data),
        .serial_valid(serial_valid),
        .transfer_request_n(transfer_request_n),
        .shift_clock(shift_clock), .random_port_own(random_port_own),
        .pixel_out(pixel_out), .blank_n(blank_n), .hsync(hsync),
        .vsync(vsync));
    vps_vram_port_model pm (.clk_sys(clk_sys), .rst_n(rst_n),
        .transfer_request_n(transfer_request_n), .delay(delay),
        .serial_data(serial_data), .serial_valid(serial_valid));
    // ----------------------------------------------
    // helpers
    // ----------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // reset, configure, then record one whole frame
    task automatic run(input logic [1:0] d, input logic acc, sp, sw, il,
                       input logic [1:0] dl);
        logic hs_prev;
        @(negedge clk_sys);
        rst_n = 1'h0;
        {depth_sel, accel_mode, split_banks, bank_swap} = {d, acc, sp, sw};
        interlaced = il;
        delay = dl;
        repeat (4) @(negedge clk_sys);
        rst_n = 1'h1;
        pix_q.delete();
        {hs_n, hs_hi, vs_hi, sh_n, hs_prev} = '0;
        repeat (HT*VT) begin
            @(negedge clk_sys);
            if (blank_n === 1'h1) pix_q.push_back(pixel_out);
            if (hsync === 1'h1 && !hs_prev) hs_n++;
            hs_hi += int'(hsync === 1'h1);
            vs_hi += int'(vsync === 1'h1);
            sh_n += int'(shift_clock === 1'h1);
            hs_prev = hsync;
        end
    endtask
    // expected stream built from the words the partner handed over
    task automatic cmp(input logic [1:0] d, input logic sw, input int min);
        logic [7:0]  e[$];
        logic [31:0] w;
        int          j;
        j = 0;
        foreach (pm.sent_q[i]) begin
            w = pm.sent_q[i];
            if (sw) w = {w[15:0], w[31:16]};
            if (d == 2'h0) for (int b = 0; b < 8; b++)
                e.push_back({4'h0, w[4*b+:4]});
            else if (d == 2'h2) e.push_back(w[7:0]);
            else for (int b = 0; b < 4; b++) e.push_back(w[8*b+:8]);
        end
        // leading zeros: shifter empty at frame start; 24-bit may idle
        foreach (pix_q[i]) begin
            if (pix_q[i] === 8'h00 && (j == 0 || d == 2'h2)) continue;
            chk(32'(pix_q[i]), 32'(e[j]));
            j++;
        end
        chk(32'(j >= min), 32'h1);
        // one shift pulse per word; the last request may still be open
        chk(32'(sh_n - pm.sent_q.size() < 2 && sh_n >= pm.sent_q.size()),
            32'h1);
    endtask
    // ----------------------------------------------
    // scenarios
    // ----------------------------------------------
    task automatic t_nibble();
        run(2'h0, 1'h0, 1'h0, 1'h0, 1'h0, 2'h2);
        cmp(2'h0, 1'h0, 56);
        chk(32'(random_port_own), 32'h1);
    endtask
    task automatic t_byte();
        for (int d = 1; d < 4; d += 2) begin
            run(2'(d), 1'h0, 1'h1, 1'h0, 1'h0, 2'h0);
            cmp(2'h1, 1'h0, 56);
        end
    endtask
    task automatic t_swap();
        run(2'h1, 1'h1, 1'h1, 1'h1, 1'h0, 2'h1);
        cmp(2'h1, 1'h1, 56);
    endtask
    task automatic t_interlace();
        run(2'h1, 1'h0, 1'h0, 1'h0, 1'h1, 2'h0);
        cmp(2'h1, 1'h0, 56);
    endtask
    task automatic t_truecolor();
        run(2'h2, 1'h0, 1'h0, 1'h0, 1'h0, 2'h0);
        cmp(2'h2, 1'h0, 16);
    endtask
    task automatic t_accel_sync();
        run(2'h1, 1'h1, 1'h0, 1'h0, 1'h0, 2'h0);
        chk(32'(random_port_own), 32'h0);
        chk(32'(hs_n), 32'hA);
        chk(32'(hs_hi), 32'h28);
        chk(32'(vs_hi), 32'h28);
        chk(32'(pix_q.size()), 32'h40);
        cmp(2'h1, 1'h0, 56);
    endtask
    // mode flips while running: port ownership follows one edge later
    task automatic t_mode_switch();
        run(2'h1, 1'h0, 1'h0, 1'h0, 1'h0, 2'h0);
        accel_mode = 1'h1;
        @(negedge clk_sys);
        chk(32'(random_port_own), 32'h0);
        accel_mode = 1'h0;
        @(negedge clk_sys);
        chk(32'(random_port_own), 32'h1);
    endtask
    task automatic wrap_up();
        $display("mismatches %0d checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // ----------------------------------------------
    // clock, watchdog, main sequence
    // ----------------------------------------------
    initial begin
        clk_sys = 1'h0;
        forever #10 clk_sys = ~clk_sys;
    end
    // a hang ends the run through the same report
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles > 6000) begin
            n_mismatch++;
            wrap_up();
        end
    end
    initial begin
        {rst_n, accel_mode, split_banks, bank_swap, interlaced} = '0;
        {depth_sel, delay} = '0;
        {n_mismatch, check_count, cycles} = '0;
        repeat (4) @(negedge clk_sys);
        t_nibble();
        t_byte();
        t_swap();
        t_interlace();
        t_truecolor();
        t_accel_sync();
        t_mode_switch();
        wrap_up();
    end
endmodule // tb_vps_pixel_shifter
`default_nettype wire
